// ===== src/emlq_pkg.sv
package emlq_pkg;
   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [3:0] IDX_EVENT_HIGH = 4'h4;
   localparam logic [3:0] IDX_EVENT_LOW = 4'h5;
   localparam logic [3:0] IDX_EVENT_MASK_HIGH = 4'h6;
   localparam logic [3:0] IDX_EVENT_MASK_LOW = 4'h7;
   localparam logic [3:0] IDX_REMOTE_SUMMARY_MASK = 4'h8;
   localparam logic [3:0] IDX_EDGE_SAMPLING_PATTERN = 4'h9;
   localparam logic [3:0] IDX_CABLE_DELAY_SIGNAL_STRENGTH = 4'hA;

   // ------------------------------------------------------------
   // field layouts and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] MASK_HIGH_WRITABLE = 8'h2F;
   localparam logic [7:0] MASK_LOW_WRITABLE = 8'h37;
   localparam logic [7:0] EVENT_HIGH_FLAGS = 8'h2F;
   localparam logic [7:0] EVENT_LOW_FLAGS = 8'h37;
   localparam int REMOTE_EVENT_BIT = 6;
   localparam int INT_STATUS_BIT = 7;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] PATTERN_RESET = 8'h00;
   localparam logic [3:0] STRENGTH_RESET = 4'h0;
   localparam logic [3:0] DELAY_RESET = 4'h0;
   localparam logic [3:0] STRENGTH_MAX = 4'hC;
   localparam logic [3:0] STRENGTH_LOW_LIMIT = 4'h2;
   localparam logic [3:0] DELAY_CODE_MAX = 4'hF;
   localparam int SAMPLES_PER_BIT = 8;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int DELAY_UNIT_NS = 100;
   localparam int DELAY_UNIT_CYC =
      (DELAY_UNIT_NS / CLK_PERIOD_NS < 1) ? 1 : DELAY_UNIT_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {DM_IDLE, DM_COUNT, DM_DONE} emlq_meas_t;
endpackage

// ===== src/emlq_top.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
module emlq_top
   import emlq_pkg::*;
#(
   parameter int SLOT_COUNT = SAMPLES_PER_BIT
)(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // event sources from the protocol engine
   input wire logic safeChannelErr,
   input wire logic fastPositionErr,
   input wire logic safePositionErr,
   input wire logic deviationThresholdErr,
   input wire logic protocolResetEvt,
   input wire logic messageInitAck,
   input wire logic longAnswerErr,
   input wire logic lowQualityWarn,
   input wire logic longChannelFree,
   input wire logic shortChannelFree,
   input wire logic [7:0] remoteSummary,
   // link quality sources
   input wire logic cableIn,
   input wire logic sampleTick,
   input wire logic startupActive,
   input wire logic delayProbe,
   input wire logic [3:0] strengthIn,
   // outputs
   output logic interruptOut,
   output logic qualityDegrade
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [7:0] maskHigh_q;
   logic [7:0] maskLow_q;
   logic [7:0] sumMask_q;
   logic [7:0] evtHigh_q;
   logic [7:0] evtLow_q;
   logic [7:0] pattern_q;
   logic [3:0] strength_q;
   logic [3:0] delayCode_q;
   logic irq_q;
   logic degrade_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   logic regSel;
   logic [3:0] regIdx;
   logic mapped;
   logic wrCommit;
   logic [7:0] wrByte;

   assign regIdx = paddr[5:2];
   assign regSel = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
   assign mapped = regSel && (regIdx >= IDX_EVENT_HIGH) &&
      (regIdx <= IDX_CABLE_DELAY_SIGNAL_STRENGTH);
   // write takes effect only at the edge that completes the access
   assign wrCommit = psel && penable && pready_q && pwrite && mapped;
   assign wrByte = pwdata[7:0];

   // ------------------------------------------------------------
   // event flag inputs
   // ------------------------------------------------------------
   logic [7:0] setHigh;
   logic [7:0] setLow;
   logic remoteFlag;
   logic remoteMask;

   assign setHigh = {2'b00, safeChannelErr, 1'b0, fastPositionErr,
      safePositionErr, deviationThresholdErr, protocolResetEvt};
   assign setLow = {2'b00, messageInitAck, longAnswerErr, 1'b0,
      lowQualityWarn, longChannelFree, shortChannelFree};
   assign remoteFlag = |(remoteSummary & sumMask_q);
   assign remoteMask = |sumMask_q;

   // ------------------------------------------------------------
   // mask registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         maskHigh_q <= MASK_RESET;
         maskLow_q <= MASK_RESET;
         sumMask_q <= MASK_RESET;
      end else if (wrCommit) begin
         if (regIdx == IDX_EVENT_MASK_HIGH) begin
            maskHigh_q <= wrByte & MASK_HIGH_WRITABLE;
         end
         if (regIdx == IDX_EVENT_MASK_LOW) begin
            maskLow_q <= wrByte & MASK_LOW_WRITABLE;
         end
         if (regIdx == IDX_REMOTE_SUMMARY_MASK) begin
            sumMask_q <= wrByte;
         end
      end
   end

   a_mask_high_zero: assert property (
      @(posedge clk) disable iff (reset)
      (maskHigh_q[7] == 1'b0) && (maskHigh_q[4] == 1'b0))
      else $error("high mask reserved bit set");

   a_mask_low_zero: assert property (
      @(posedge clk) disable iff (reset)
      (maskLow_q & ~MASK_LOW_WRITABLE) == 8'h00)
      else $error("low mask reserved bit set");

   // ------------------------------------------------------------
   // event flags: write one to clear, a new set wins
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         evtHigh_q <= 8'h00;
         evtLow_q <= 8'h00;
      end else begin
         // hardware never clears; only host writes do
         evtHigh_q <= ((evtHigh_q &
            ~((wrCommit && regIdx == IDX_EVENT_HIGH) ? wrByte : 8'h00))
            | setHigh) & EVENT_HIGH_FLAGS;
         evtLow_q <= ((evtLow_q &
            ~((wrCommit && regIdx == IDX_EVENT_LOW) ? wrByte : 8'h00))
            | setLow) & EVENT_LOW_FLAGS;
      end
   end

   a_flag_sticky: assert property (
      @(posedge clk) disable iff (reset)
      (evtLow_q[1] && !(wrCommit && regIdx == IDX_EVENT_LOW && wrByte[1]))
      |=> evtLow_q[1])
      else $error("event flag cleared without host write");

   a_set_wins: assert property (
      @(posedge clk) disable iff (reset)
      shortChannelFree |=> evtLow_q[0])
      else $error("event set lost");

   // ------------------------------------------------------------
   // interrupt combine
   // ------------------------------------------------------------
   logic irq_d;
   assign irq_d = (|(evtHigh_q & maskHigh_q)) | (|(evtLow_q & maskLow_q))
      | (remoteFlag & remoteMask);

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   a_irq_follows_flags: assert property (
      @(posedge clk) disable iff (reset)
      $rose(|(evtHigh_q & maskHigh_q)) |=> irq_q)
      else $error("masked high flag did not raise interrupt");

   a_irq_needs_cause: assert property (
      @(posedge clk) disable iff (reset)
      ((evtHigh_q & maskHigh_q) == 8'h00 && (evtLow_q & maskLow_q) == 8'h00
       && !(remoteFlag && remoteMask)) |=> !irq_q)
      else $error("interrupt without masked cause");

   a_remote_path: assert property (
      @(posedge clk) disable iff (reset)
      (remoteFlag && remoteMask) |=> irq_q)
      else $error("remote summary event did not interrupt");

   // ------------------------------------------------------------
   // cable input synchroniser and edge sampling
   // ------------------------------------------------------------
   logic cableMeta_q;
   logic cableSync_q;
   logic cablePrev_q;
   logic [2:0] slot_q;
   logic patternLocked_q;
   logic cableEdge;

   always_ff @(posedge clk) begin
      if (reset) begin
         cableMeta_q <= 1'b0;
         cableSync_q <= 1'b0;
      end else begin
         cableMeta_q <= cableIn;
         cableSync_q <= cableMeta_q;
      end
   end

   // an edge is a change between two successive samples
   assign cableEdge = sampleTick && (cableSync_q != cablePrev_q);

   always_ff @(posedge clk) begin
      if (reset) begin
         cablePrev_q <= 1'b0;
         slot_q <= 3'h0;
      end else if (protocolResetEvt) begin
         slot_q <= 3'h0;
      end else if (sampleTick) begin
         cablePrev_q <= cableSync_q;
         slot_q <= (slot_q == 3'(SLOT_COUNT - 1)) ? 3'h0
            : slot_q + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pattern_q <= PATTERN_RESET;
         patternLocked_q <= 1'b0;
      end else if (protocolResetEvt) begin
         // forced protocol reset re-arms a fresh capture
         pattern_q <= PATTERN_RESET;
         patternLocked_q <= 1'b0;
      end else if (!patternLocked_q) begin
         if (startupActive && cableEdge) begin
            pattern_q[slot_q] <= 1'b1;
         end
         if (!startupActive && |pattern_q) begin
            patternLocked_q <= 1'b1;
         end
      end
   end

   a_pattern_frozen: assert property (
      @(posedge clk) disable iff (reset)
      (patternLocked_q && !protocolResetEvt) |=> $stable(pattern_q))
      else $error("edge pattern changed after start-up");

   // ------------------------------------------------------------
   // round trip delay measurement
   // ------------------------------------------------------------
   localparam int UNIT_W = $clog2(DELAY_UNIT_CYC + 1);
   emlq_meas_t meas_q;
   logic [UNIT_W-1:0] unitCnt_q;
   logic [3:0] measCode_q;

   always_ff @(posedge clk) begin
      if (reset) begin
         meas_q <= DM_IDLE;
         unitCnt_q <= '0;
         measCode_q <= DELAY_RESET;
         delayCode_q <= DELAY_RESET;
      end else if (protocolResetEvt) begin
         meas_q <= DM_IDLE;
         delayCode_q <= DELAY_RESET;
      end else begin
         unique case (meas_q)
            DM_IDLE: begin
               if (delayProbe) begin
                  meas_q <= DM_COUNT;
                  unitCnt_q <= '0;
                  measCode_q <= DELAY_RESET;
               end
            end
            DM_COUNT: begin
               if (cableEdge) begin
                  meas_q <= DM_DONE;
                  delayCode_q <= measCode_q;
               end else if (unitCnt_q == UNIT_W'(DELAY_UNIT_CYC - 1)) begin
                  unitCnt_q <= '0;
                  // each 100 ns step adds one code
                  if (measCode_q != DELAY_CODE_MAX) begin
                     measCode_q <= measCode_q + 4'h1;
                  end
               end else begin
                  unitCnt_q <= unitCnt_q + UNIT_W'(1);
               end
            end
            DM_DONE: begin
               meas_q <= DM_DONE;
            end
         endcase
      end
   end

   a_delay_held: assert property (
      @(posedge clk) disable iff (reset)
      (meas_q == DM_DONE && !protocolResetEvt) |=> $stable(delayCode_q))
      else $error("cable delay changed outside measurement");

   // ------------------------------------------------------------
   // signal strength, continuously tracked
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         strength_q <= STRENGTH_RESET;
         degrade_q <= 1'b0;
      end else begin
         // receiver may report above range; clamp to the scale top
         strength_q <= (strengthIn > STRENGTH_MAX) ? STRENGTH_MAX
            : strengthIn;
         degrade_q <= (strength_q < STRENGTH_LOW_LIMIT);
      end
   end

   a_strength_range: assert property (
      @(posedge clk) disable iff (reset)
      strength_q <= STRENGTH_MAX)
      else $error("strength beyond scale");

   a_degrade_low: assert property (
      @(posedge clk) disable iff (reset)
      (strength_q < STRENGTH_LOW_LIMIT) |=> degrade_q)
      else $error("low strength did not degrade quality");

   // ------------------------------------------------------------
   // apb read path, one wait-free access phase
   // ------------------------------------------------------------
   logic [7:0] rdByte;
   always_comb begin
      rdByte = 8'h00;
      unique case (regIdx)
         IDX_EVENT_HIGH: begin
            rdByte = evtHigh_q;
            rdByte[INT_STATUS_BIT] = irq_q;
            rdByte[REMOTE_EVENT_BIT] = remoteFlag;
         end
         IDX_EVENT_LOW: rdByte = evtLow_q;
         IDX_EVENT_MASK_HIGH: begin
            rdByte = maskHigh_q;
            rdByte[REMOTE_EVENT_BIT] = remoteMask;
         end
         IDX_EVENT_MASK_LOW: rdByte = maskLow_q;
         IDX_REMOTE_SUMMARY_MASK: rdByte = sumMask_q;
         IDX_EDGE_SAMPLING_PATTERN: rdByte = pattern_q;
         IDX_CABLE_DELAY_SIGNAL_STRENGTH: begin
            rdByte = {strength_q, delayCode_q};
         end
         default: rdByte = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel && !penable;
         pslverr_q <= psel && !penable && !mapped;
         if (psel && !penable && !pwrite && mapped) begin
            prdata_q <= {24'h00_0000, rdByte};
         end else if (psel && !penable) begin
            prdata_q <= 32'h0000_0000;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign interruptOut = irq_q;
   assign qualityDegrade = degrade_q;

   a_apb_ready: assert property (
      @(posedge clk) disable iff (reset)
      (psel && !penable) |=> pready_q)
      else $error("access phase not answered next cycle");
endmodule

// ===== tb/emlq_remote.sv
`timescale 1ns/1ns
module emlq_remote (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // commands from the bench
   input wire logic startupActive,
   input wire logic delayProbe,
   input wire logic [9:0] echoCycles,
   input wire logic [2:0] edgeSlot,
   // cable side
   output logic cableIn,
   output logic sampleTick
);
   logic [2:0] slot_q;
   logic [9:0] echo_q;

   // ------------------------------------------------------------
   // sampling ticks
   // ------------------------------------------------------------
   // one tick per clock, so a cable bit spans eight clocks
   always_ff @(posedge clk) begin
      if (reset) begin
         slot_q <= 3'h0;
         sampleTick <= 1'b0;
      end else begin
         slot_q <= slot_q + 3'h1;
         sampleTick <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // cable line
   // ------------------------------------------------------------
   // clean test signal: during start-up one transition per bit, in slot edgeSlot; otherwise only the echo edge
   always_ff @(posedge clk) begin
      if (reset) begin
         cableIn <= 1'b0;
      end else if (startupActive && slot_q == edgeSlot) begin
         cableIn <= ~cableIn;
      end else if (echo_q == 10'h001) begin
         cableIn <= ~cableIn;
      end
   end

   // round trip: the answer edge comes echoCycles clocks after probe
   always_ff @(posedge clk) begin
      if (reset) begin
         echo_q <= 10'h000;
      end else if (delayProbe) begin
         echo_q <= echoCycles;
      end else if (echo_q != 10'h000) begin
         echo_q <= echo_q - 10'h001;
      end
   end
endmodule

// ===== tb/test_emlq_top.sv
`timescale 1ns/1ns
module test_emlq_top;
   import emlq_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, interruptOut, qualityDegrade;
   logic [9:0] src = 10'h000;
   logic [7:0] remoteSummary = 8'h00;
   logic startupActive = 1'b0;
   logic delayProbe = 1'b0;
   logic [3:0] strengthIn = 4'h0;
   logic [9:0] echoCycles = 10'h000;
   logic [2:0] edgeSlot = 3'h0;
   logic cableIn, sampleTick;
   int mismatches = 0;
   int comparisons = 0;
   int cycles = 0;
   int bitPos [10] = '{5, 3, 2, 1, 0, 5, 4, 2, 1, 0};

   always #2 clk = ~clk;

   emlq_remote remote (.clk(clk), .reset(reset),
      .startupActive(startupActive), .delayProbe(delayProbe),
      .echoCycles(echoCycles), .edgeSlot(edgeSlot),
      .cableIn(cableIn), .sampleTick(sampleTick));

   emlq_top dut (.clk(clk), .reset(reset), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .safeChannelErr(src[0]),
      .fastPositionErr(src[1]), .safePositionErr(src[2]),
      .deviationThresholdErr(src[3]), .protocolResetEvt(src[4]),
      .messageInitAck(src[5]), .longAnswerErr(src[6]),
      .lowQualityWarn(src[7]), .longChannelFree(src[8]),
      .shortChannelFree(src[9]), .remoteSummary(remoteSummary),
      .cableIn(cableIn), .sampleTick(sampleTick),
      .startupActive(startupActive), .delayProbe(delayProbe),
      .strengthIn(strengthIn), .interruptOut(interruptOut),
      .qualityDegrade(qualityDegrade));

   // ------------------------------------------------------------
   // reporting
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // a hung handshake ends here
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         wrap_up();
      end
   end

   // ------------------------------------------------------------
   // bus and stimulus helpers
   // ------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] rd, output logic er);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'b1, a, d, x, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic e;
      apb(1'b0, a, 32'h0, v, e);
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      src[i] <= 1'b1;
      @(posedge clk);
      src[i] <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic probe(input logic [9:0] n);
      @(posedge clk);
      echoCycles <= n;
      delayProbe <= 1'b1;
      @(posedge clk);
      delayProbe <= 1'b0;
      repeat (int'(n) + 20) @(posedge clk);
   endtask

   task automatic startup(input logic [2:0] s);
      @(posedge clk);
      edgeSlot <= s;
      startupActive <= 1'b1;
      repeat (64) @(posedge clk);
      startupActive <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      logic [31:0] v;
      logic e;
      for (int i = 0; i < 5; i++) begin
         rd(8'h18 + 8'(4 * i), v);
         check(v, 32'h0);
      end
      wr(8'h18, 32'hFF);
      rd(8'h18, v);
      check(v, 32'h2F);
      wr(8'h1C, 32'hFF);
      rd(8'h1C, v);
      check(v, 32'h37);
      wr(8'h24, 32'hFF);
      rd(8'h24, v);
      check(v, 32'h0);
      apb(1'b0, 8'h2C, 32'h0, v, e);
      check({v[30:0], e}, 32'h1);
      wr(8'h18, 32'h0);
      wr(8'h1C, 32'h0);
   endtask

   task automatic t_events();
      logic [31:0] v;
      logic [7:0] ma, ea, b;
      for (int i = 0; i < 10; i++) begin
         ma = (i < 5) ? 8'h18 : 8'h1C;
         ea = (i < 5) ? 8'h10 : 8'h14;
         b = 8'h01 << bitPos[i];
         wr(ma, {24'h0, b});
         pulse(i);
         check({31'h0, interruptOut}, 32'h1);
         rd(8'h10, v);
         check({31'h0, v[7]}, 32'h1);
         wr(ma, 32'h0);
         repeat (3) @(posedge clk);
         check({31'h0, interruptOut}, 32'h0);
         pulse(i);
         check({31'h0, interruptOut}, 32'h0);
         rd(ea, v);
         check(v & {24'h0, b}, {24'h0, b});
         wr(ea, {24'h0, b});
         rd(ea, v);
         check(v & {24'h0, b}, 32'h0);
      end
   endtask

   task automatic t_summary();
      logic [31:0] v;
      wr(8'h20, 32'h10);
      rd(8'h20, v);
      check(v, 32'h10);
      rd(8'h18, v);
      check(v, 32'h40);
      remoteSummary <= 8'h01;
      repeat (3) @(posedge clk);
      check({31'h0, interruptOut}, 32'h0);
      rd(8'h10, v);
      check({31'h0, v[6]}, 32'h0);
      remoteSummary <= 8'h10;
      repeat (3) @(posedge clk);
      check({31'h0, interruptOut}, 32'h1);
      rd(8'h10, v);
      check({31'h0, v[6]}, 32'h1);
      wr(8'h20, 32'h0);
      remoteSummary <= 8'hFF;
      repeat (3) @(posedge clk);
      check({31'h0, interruptOut}, 32'h0);
      remoteSummary <= 8'h00;
   endtask

   task automatic t_link();
      logic [31:0] p1, p2, v;
      logic [3:0] vals [4] = '{4'h1, 4'h2, 4'hC, 4'hF};
      pulse(4);
      startup(3'h2);
      rd(8'h24, p1);
      check(32'($countones(p1)), 32'h1);
      startup(3'h5);
      rd(8'h24, p2);
      check(p2, p1);
      pulse(4);
      startup(3'h5);
      rd(8'h24, p2);
      check({31'h0, p2 === p1}, 32'h0);
      // 240 clocks are 960 ns of round trip
      probe(10'h0F0);
      rd(8'h28, v);
      check({28'h0, v[3:0]}, 32'h9);
      probe(10'h064);
      rd(8'h28, v);
      check({28'h0, v[3:0]}, 32'h9);
      pulse(4);
      probe(10'h1F4);
      rd(8'h28, v);
      check({28'h0, v[3:0]}, 32'hF);
      foreach (vals[i]) begin
         strengthIn <= vals[i];
         repeat (4) @(posedge clk);
         rd(8'h28, v);
         check({28'h0, v[7:4]}, 32'(vals[i] > 4'hC ? 4'hC : vals[i]));
         check({31'h0, qualityDegrade}, 32'(vals[i] < 4'h2));
      end
   endtask

   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_events();
      t_summary();
      t_link();
      wrap_up();
   end
endmodule
